// ==== core/pfm_pkg.sv ====
/*
  Package of the press fault monitor: fault flag positions in the three
  fault words, stroke and batch constants, timing figures and counts.
  Assumes a single 125 MHz system clock; the millisecond and inactivity cycle counts derive from it.
*/
package pfm_pkg;

  // Clock and word widths
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned FW_WIDTH      = 16;
  localparam int unsigned VAL_WIDTH     = 16;

  // Fault word one flag positions
  localparam int unsigned F1_SPEED_THRESHOLD_A      = 0;
  localparam int unsigned F1_NO_MOTION  = 1;
  localparam int unsigned F1_BRAKE_WARN = 2;
  localparam int unsigned F1_BRAKE_FAIL = 3;
  localparam int unsigned F1_MIN_SPEED  = 6;
  localparam int unsigned F1_DIE        = 15;

  // Fault word two flag positions
  localparam int unsigned F2_RAM_BAD    = 0;
  localparam int unsigned F2_NOISY      = 7;
  localparam int unsigned F2_PAGE0      = 10;
  localparam int unsigned F2_PAGE1      = 11;

  // Fault word three flag positions
  localparam int unsigned F3_NV_STORE   = 3;
  localparam int unsigned F3_INACTIVE   = 4;
  localparam int unsigned F3_LC_CONFIG  = 9;
  localparam int unsigned F3_STROKE_LIM = 13;

  // Reset values
  localparam logic [15:0] FW_RESET      = 16'h0000;
  localparam logic        CNT_OUT_RESET = 1'b1;

  // Stroke figures
  localparam logic [3:0]  SETUP_STROKE_LIMIT = 4'hF;
  localparam logic [1:0]  MIN_SPEED_STROKES  = 2'h3;

  // Light curtains and die sensors
  localparam int unsigned LC_COUNT  = 5;
  localparam int unsigned DIE_COUNT = 8;

  // Timing: one millisecond tick for the motion setpoint
  localparam int unsigned MS_TIME_NS = 1000000;
  localparam int unsigned MS_CYCLES  = MS_TIME_NS / CLK_PERIOD_NS;

  // Timing: inactivity timeout in minutes
  localparam longint unsigned INACT_MINUTES = 20;
  localparam longint unsigned INACT_CYCLES  =
    (INACT_MINUTES * 64'd60 * 64'd1000000000) / CLK_PERIOD_NS;

  // Input filter: samples to call stable, cycles before calling noisy
  localparam int unsigned STABLE_SAMPLES = 4;
  localparam int unsigned NOISY_CYCLES   = 1024;

endpackage

// ==== core/pfm_input_filter.sv ====
/*
  Opto input conditioner: two-flop synchroniser followed by a stability
  filter over the whole input vector, and a noisy-input event.
  Assumes raw inputs are asynchronous to ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module pfm_input_filter #(
  parameter int unsigned WIDTH  = 18,
  parameter int unsigned STABLE = 4,
  parameter int unsigned NOISY  = 1024
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Raw and conditioned inputs
  input  wire logic [WIDTH-1:0] raw_in,
  output logic      [WIDTH-1:0] clean_out,
  output logic                  noisy_pulse
);
  import pfm_pkg::*;

  logic [WIDTH-1:0] sync_a;
  logic [WIDTH-1:0] sync_b;
  logic [WIDTH-1:0] last_sample;
  logic [15:0]      stable_cnt;
  logic [15:0]      unsettled_cnt;

  // Two-flop synchroniser; sync_a feeds sync_b and nothing else
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  // Count consecutive equal samples; any bit change restarts the run
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_sample <= '0;
      stable_cnt  <= 16'h0000;
    end else begin
      last_sample <= sync_b;
      if (sync_b != last_sample) begin
        stable_cnt <= 16'h0000;
      end else if (stable_cnt < 16'(STABLE)) begin
        stable_cnt <= stable_cnt + 16'h0001;
      end
    end
  end

  // Take the sample once settled
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clean_out <= '0;
    end else if (stable_cnt == 16'(STABLE)) begin
      clean_out <= last_sample;
    end
  end

  // Noisy when the vector never settles within the window; a chattering bit
  // that keeps passing through its clean value must not restart the window
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      unsettled_cnt <= 16'h0000;
      noisy_pulse   <= 1'b0;
    end else begin
      noisy_pulse <= 1'b0;
      if (stable_cnt == 16'(STABLE)) begin
        unsettled_cnt <= 16'h0000;
      end else if (unsettled_cnt == 16'(NOISY - 1)) begin
        unsettled_cnt <= 16'h0000;
        noisy_pulse   <= 1'b1;
      end else begin
        unsettled_cnt <= unsettled_cnt + 16'h0001;
      end
    end
  end

  // Noise event only after a full unsettled window
  a_noisy_window: assert property (@(posedge ref_clk) disable iff (rst)
    noisy_pulse |-> $past(unsettled_cnt) == 16'(NOISY - 1))
    else $error("noisy event without full unsettled window");

endmodule
`default_nettype wire

// ==== core/pfm_monitor.sv ====
/*
  Press fault monitor top: sets one-hot flags in three sixteen-bit fault
  words from press measurements, job memory checks and light curtain
  inputs; operator acknowledge clears them, the stroke limit flag only
  in setup mode. Measurements, setpoints and panel strobes come from
  logic on ref_clk; contact inputs are pins.

*/
`timescale 1ns/1ns
`default_nettype none
module pfm_monitor #(
  parameter int unsigned     MS_TICK     = pfm_pkg::MS_CYCLES,
  parameter longint unsigned INACT_TICKS = pfm_pkg::INACT_CYCLES
) (
  // Clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  // Operator panel and mode
  input  wire logic                          program_setup_mode,
  input  wire logic                          fault_ack,
  input  wire logic                          inactivity_enable,
  input  wire logic [1:0]                    palm_station_en,
  // Press measurements
  input  wire logic                          stroke_done,
  input  wire logic                          crank_step,
  input  wire logic                          spm_valid,
  input  wire logic [pfm_pkg::VAL_WIDTH-1:0] spm,
  input  wire logic                          stop_valid,
  input  wire logic [pfm_pkg::VAL_WIDTH-1:0] stop_time,
  input  wire logic                          motion_cmd,
  input  wire logic                          part_done,
  // Setpoints
  input  wire logic [pfm_pkg::VAL_WIDTH-1:0] min_speed_set,
  input  wire logic [pfm_pkg::VAL_WIDTH-1:0] speed_threshold_a,
  input  wire logic [pfm_pkg::VAL_WIDTH-1:0] brake_fail_set,
  input  wire logic [pfm_pkg::VAL_WIDTH-1:0] brake_warn_set,
  input  wire logic [pfm_pkg::VAL_WIDTH-1:0] motion_time_set,
  input  wire logic [pfm_pkg::VAL_WIDTH-1:0] batch_size_set,
  // Die sensors and memory checks
  input  wire logic [pfm_pkg::DIE_COUNT-1:0] die_fault_evt,
  input  wire logic                          nv_write_fail,
  input  wire logic                          ram_check_fail,
  input  wire logic                          page_check_valid,
  input  wire logic                          page_sel,
  input  wire logic [pfm_pkg::VAL_WIDTH-1:0] page_sum_calc,
  input  wire logic [pfm_pkg::VAL_WIDTH-1:0] page_sum_stored,
  // Contact pins
  input  wire logic                          clutch_pin,
  input  wire logic                          motor_on_pin,
  input  wire logic                          counter_reset_pin,
  input  wire logic [pfm_pkg::LC_COUNT-1:0]  lc_master_pin,
  input  wire logic [pfm_pkg::LC_COUNT-1:0]  lc_slave_pin,
  input  wire logic [pfm_pkg::LC_COUNT-1:0]  lc_key_pin,
  // Fault words and outputs
  output logic      [pfm_pkg::FW_WIDTH-1:0]  fault_word_one,
  output logic      [pfm_pkg::FW_WIDTH-1:0]  fault_word_two,
  output logic      [pfm_pkg::FW_WIDTH-1:0]  fault_word_three,
  output logic      [pfm_pkg::DIE_COUNT-1:0] die_fault_list,
  output logic                               counter_out,
  output logic                               press_inhibit,
  output logic                               curtain_trip,
  output logic                               config_reject
);
  import pfm_pkg::*;

  localparam int unsigned PIN_W = 3 + 3 * LC_COUNT;

  logic [PIN_W-1:0]    pins_clean;
  logic                noisy_evt;
  logic                clutch;
  logic                motor_on;
  logic                counter_btn;
  logic [LC_COUNT-1:0] lc_master;
  logic [LC_COUNT-1:0] lc_slave;
  logic [LC_COUNT-1:0] lc_key;
  logic [3:0]          setup_strokes;
  logic [1:0]          run_strokes;
  logic [VAL_WIDTH-1:0] part_count;
  logic [31:0]         ms_cnt;
  logic [VAL_WIDTH-1:0] motion_ms;
  logic [63:0]         idle_cnt;
  logic [FW_WIDTH-1:0] set1, set2, set3;
  logic [FW_WIDTH-1:0] clr3;
  logic                conflict;

  // Contact inputs are synchronised and checked for stability
  pfm_input_filter #(
    .WIDTH  (PIN_W),
    .STABLE (STABLE_SAMPLES),
    .NOISY  (NOISY_CYCLES)
  ) u_filter (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .raw_in      ({lc_key_pin, lc_slave_pin, lc_master_pin,
                   counter_reset_pin, motor_on_pin, clutch_pin}),
    .clean_out   (pins_clean),
    .noisy_pulse (noisy_evt)
  );

  assign clutch      = pins_clean[0];
  assign motor_on    = pins_clean[1];
  assign counter_btn = pins_clean[2];
  assign lc_master   = pins_clean[3 +: LC_COUNT];
  assign lc_slave    = pins_clean[3 + LC_COUNT +: LC_COUNT];
  assign lc_key      = pins_clean[3 + 2 * LC_COUNT +: LC_COUNT];

  // Setup-mode stroke counter, restarted on leaving setup or on ack
  always_ff @(posedge ref_clk) begin
    if (rst || !program_setup_mode || fault_ack) begin
      setup_strokes <= 4'h0;
    end else if (stroke_done && setup_strokes != SETUP_STROKE_LIMIT) begin
      setup_strokes <= setup_strokes + 4'h1;
    end
  end

  // Strokes since motor start, saturating at three
  always_ff @(posedge ref_clk) begin
    if (rst || !motor_on) begin
      run_strokes <= 2'h0;
    end else if (stroke_done && run_strokes != MIN_SPEED_STROKES) begin
      run_strokes <= run_strokes + 2'h1;
    end
  end

  // Millisecond timer runs only while motion is awaited
  always_ff @(posedge ref_clk) begin
    if (rst || !motion_cmd || crank_step) begin
      ms_cnt    <= 32'h00000000;
      motion_ms <= 16'h0000;
    end else if (ms_cnt == 32'(MS_TICK - 1)) begin
      ms_cnt <= 32'h00000000;
      if (motion_ms != 16'hFFFF) begin
        motion_ms <= motion_ms + 16'h0001;
      end
    end else begin
      ms_cnt <= ms_cnt + 32'h00000001;
    end
  end

  // Idle timer restarts on every stroke and while the motor is off
  always_ff @(posedge ref_clk) begin
    if (rst || !motor_on || stroke_done) begin
      idle_cnt <= 64'h0000000000000000;
    end else if (idle_cnt != INACT_TICKS) begin
      idle_cnt <= idle_cnt + 64'h0000000000000001;
    end
  end

  // Curtains three to five clash with palm stations two and three
  assign conflict = (|lc_key[LC_COUNT-1:2]) && (|palm_station_en);

  // Fault word one events
  always_comb begin
    set1 = FW_RESET;
    set1[F1_SPEED_THRESHOLD_A]      = spm_valid && !clutch && (spm > speed_threshold_a);
    set1[F1_NO_MOTION]  = motion_cmd && (motion_ms >= motion_time_set)
                          && (motion_time_set != 16'h0000);
    set1[F1_BRAKE_WARN] = stop_valid && (stop_time > brake_warn_set);
    set1[F1_BRAKE_FAIL] = stop_valid && (stop_time > brake_fail_set);
    // Minimum speed only after three strokes
    set1[F1_MIN_SPEED]  = spm_valid && (run_strokes == MIN_SPEED_STROKES)
                          && (spm < min_speed_set);
    set1[F1_DIE]        = |die_fault_evt;
  end

  // Fault word two events
  always_comb begin
    set2 = FW_RESET;
    set2[F2_RAM_BAD] = ram_check_fail;
    set2[F2_NOISY]   = noisy_evt;
    // Page checksum, not in setup mode
    set2[F2_PAGE0]   = page_check_valid && !program_setup_mode && !page_sel
                       && (page_sum_calc != page_sum_stored);
    set2[F2_PAGE1]   = page_check_valid && !program_setup_mode && page_sel
                       && (page_sum_calc != page_sum_stored);
  end

  // Fault word three events and the acknowledge mask
  always_comb begin
    set3 = FW_RESET;
    clr3 = {FW_WIDTH{fault_ack}};
    set3[F3_NV_STORE]   = nv_write_fail;
    set3[F3_INACTIVE]   = inactivity_enable && motor_on && (idle_cnt == INACT_TICKS);
    set3[F3_LC_CONFIG]  = conflict;
    set3[F3_STROKE_LIM] = program_setup_mode && stroke_done
                          && (setup_strokes == SETUP_STROKE_LIMIT - 4'h1);
    // Acknowledge clears this flag only in setup mode
    clr3[F3_STROKE_LIM] = fault_ack && program_setup_mode;
  end

  // Sticky fault words; a set in the ack cycle wins over the clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fault_word_one   <= FW_RESET;
      fault_word_two   <= FW_RESET;
      fault_word_three <= FW_RESET;
    end else begin
      fault_word_one   <= (fault_word_one & ~{FW_WIDTH{fault_ack}}) | set1;
      fault_word_two   <= (fault_word_two & ~{FW_WIDTH{fault_ack}}) | set2;
      fault_word_three <= (fault_word_three & ~clr3) | set3;
    end
  end

  // Record every faulting die sensor for listing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      die_fault_list <= '0;
    end else begin
      die_fault_list <= (die_fault_list & ~{DIE_COUNT{fault_ack}}) | die_fault_evt;
    end
  end

  // Inhibit follows the fault words; a cycle late, never early
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      press_inhibit <= 1'b1;
    end else begin
      press_inhibit <= (|fault_word_one) || (|fault_word_two) || (|fault_word_three);
    end
  end

  // Part counter and silent batch drop-out; only the button restores
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      part_count  <= 16'h0000;
      counter_out <= CNT_OUT_RESET;
    end else if (counter_btn) begin
      part_count  <= 16'h0000;
      counter_out <= CNT_OUT_RESET;
    end else begin
      if (part_done && part_count != 16'hFFFF) begin
        part_count <= part_count + 16'h0001;
      end
      if (batch_size_set != 16'h0000 && part_count >= batch_size_set) begin
        counter_out <= 1'b0;
      end
    end
  end

  // Channels independent: either open contact trips a monitored curtain
  // Keyswitch selects monitoring; rejected curtains still trip
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      curtain_trip  <= 1'b1;
      config_reject <= 1'b0;
    end else begin
      curtain_trip  <= |(lc_key & ~(lc_master & lc_slave));
      config_reject <= conflict;
    end
  end

  // Assertions
  sequence s_setup_strokes_done;
    program_setup_mode && stroke_done && setup_strokes == 4'hE;
  endsequence

  a_stroke_limit_set: assert property (@(posedge ref_clk) disable iff (rst)
    s_setup_strokes_done |=> fault_word_three[F3_STROKE_LIM])
    else $error("stroke limit not set on fifteenth setup stroke");

  a_stroke_ack_run: assert property (@(posedge ref_clk) disable iff (rst)
    fault_word_three[F3_STROKE_LIM] && !program_setup_mode |=>
      fault_word_three[F3_STROKE_LIM])
    else $error("stroke limit flag cleared outside setup mode");

  a_batch_dropout: assert property (@(posedge ref_clk) disable iff (rst)
    !counter_out && !counter_btn |=> !counter_out)
    else $error("counter output restored without button");

  a_min_speed_gate: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(fault_word_one[F1_MIN_SPEED]) |-> $past(run_strokes) == 2'h3)
    else $error("min speed flagged before three strokes");

  a_brake_fail: assert property (@(posedge ref_clk) disable iff (rst)
    stop_valid && stop_time > brake_fail_set |=> fault_word_one[F1_BRAKE_FAIL])
    else $error("brake fail not flagged");

  a_brake_warn: assert property (@(posedge ref_clk) disable iff (rst)
    stop_valid && stop_time > brake_warn_set |=> fault_word_one[F1_BRAKE_WARN])
    else $error("brake warning not flagged");

  a_die_record: assert property (@(posedge ref_clk) disable iff (rst)
    |die_fault_evt |=> fault_word_one[F1_DIE] && (die_fault_list & $past(die_fault_evt))
      == $past(die_fault_evt))
    else $error("die fault not recorded");

  a_speed_threshold_a_clutch: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(fault_word_one[F1_SPEED_THRESHOLD_A]) |-> !$past(clutch))
    else $error("speed_threshold_a flagged with clutch engaged");

  a_nv_store: assert property (@(posedge ref_clk) disable iff (rst)
    nv_write_fail |=> fault_word_three[F3_NV_STORE])
    else $error("store failure not flagged");

  a_page_setup: assert property (@(posedge ref_clk) disable iff (rst)
    program_setup_mode && !fault_word_two[F2_PAGE0] |=> !fault_word_two[F2_PAGE0])
    else $error("page check ran in setup mode");

  a_ram_ack: assert property (@(posedge ref_clk) disable iff (rst)
    fault_ack && !ram_check_fail |=> !fault_word_two[F2_RAM_BAD])
    else $error("memory fault not cleared by ack");

  a_curtain_reject: assert property (@(posedge ref_clk) disable iff (rst)
    conflict |=> config_reject ##0 fault_word_three[F3_LC_CONFIG])
    else $error("curtain palm conflict not rejected");

  a_inhibit_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (|fault_word_one) |=> press_inhibit)
    else $error("press not inhibited with fault set");

endmodule
`default_nettype wire

// ==== test/pfm_press_model.sv ====
/*
  Press-side sensor model: answers a motion command with crank steps.
  Assumes the bench sets the lag; a lag of zero models a stalled press.
*/
`timescale 1ns/1ns
`default_nettype none
module pfm_press_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Command and response
  input  wire logic       motion_cmd,
  input  wire logic [7:0] lag,
  output logic            crank_step
);
  logic [7:0] cnt;
  // Crank steps start lag cycles after the command; a real press never moves at once
  always_ff @(posedge ref_clk) begin
    if (rst || !motion_cmd) cnt <= 8'h00;
    else if (cnt != 8'hFF) cnt <= cnt + 8'h01;
    crank_step <= !rst && motion_cmd && lag != 8'h00 && cnt >= lag;
  end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
/*
  Bench of the press fault monitor: fixed-seed random and corner stimulus,
  expected flags worked out from the flag map. Assumes short tick counts.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import pfm_pkg::*;
  // Stimulus and observed signals, named as the ports
  logic        ref_clk, rst, program_setup_mode, fault_ack, inactivity_enable;
  logic        crank_step, motion_cmd, page_sel, clutch_pin, motor_on_pin, counter_reset_pin;
  logic        counter_out, press_inhibit, curtain_trip, config_reject;
  logic [1:0]  palm_station_en;
  logic [6:0]  pv;
  logic [7:0]  die_fault_evt, die_fault_list, lag;
  logic [4:0]  lc_master_pin, lc_slave_pin, lc_key_pin;
  logic [15:0] spm, stop_time, min_speed_set, speed_threshold_a, brake_fail_set;
  logic [15:0] brake_warn_set, motion_time_set, batch_size_set, page_sum_calc, page_sum_stored;
  logic [15:0] fault_word_one, fault_word_two, fault_word_three;
  logic [51:0] mon;
  logic [31:0] seed, r;
  int          err_count, compares, n;
  localparam logic [15:0] nil = 16'h0000;
  // Flags and outputs in one vector so a single wait task serves all
  assign mon = {counter_out, curtain_trip, config_reject, press_inhibit,
                fault_word_three, fault_word_two, fault_word_one};
  pfm_monitor #(.MS_TICK(10), .INACT_TICKS(200)) dut (
    .*,
    .stroke_done(pv[0]), .part_done(pv[1]), .nv_write_fail(pv[2]), .ram_check_fail(pv[3]),
    .page_check_valid(pv[4]), .stop_valid(pv[5]), .spm_valid(pv[6]));
  pfm_press_model pm (.ref_clk, .rst, .motion_cmd, .lag, .crank_step);
  // Clock of 8 ns
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] oh(input int b);
    return 16'h0001 << b;
  endfunction
  // Both brake flags compare strictly above their setpoints
  function automatic logic [15:0] brk(input logic [15:0] v);
    return (v > brake_warn_set ? oh(F1_BRAKE_WARN) : nil) |
           (v > brake_fail_set ? oh(F1_BRAKE_FAIL) : nil);
  endfunction
  task automatic close_out();
    $display("counts: %0d mismatches, %0d compares", err_count, compares);
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  // One-cycle strobes; the flag shows on the same edge that takes the strobe
  task automatic pulse(input logic [6:0] m);
    @(posedge ref_clk);
    pv <= m;
    @(posedge ref_clk);
    pv <= 7'h00;
  endtask
  task automatic words(input string nm, input logic [15:0] a, b, c);
    #1;
    chk({nm, " w1"}, a, fault_word_one);
    chk({nm, " w2"}, b, fault_word_two);
    chk({nm, " w3"}, c, fault_word_three);
  endtask
  // Bounded wait; running out of cycles ends the run
  task automatic waitv(input string nm, input int i, input logic v, input int lim);
    #1;
    n = 0;
    while (mon[i] !== v && n < lim) begin
      #8;
      n++;
    end
    chk(nm, {15'h0000, v}, {15'h0000, mon[i]});
    if (n >= lim) close_out();
  endtask
  // Acknowledge, then expect what survives it and the matching inhibit
  task automatic ackw(input logic [15:0] a, b, c);
    @(posedge ref_clk);
    fault_ack <= 1'b1;
    @(posedge ref_clk);
    fault_ack <= 1'b0;
    cyc(1);
    words("ack", a, b, c);
    chk("press_inhibit", {15'h0000, (a | b | c) != nil}, {15'h0000, press_inhibit});
  endtask
  initial begin
    #400000;
    err_count++;
    close_out();
  end
  initial begin
    seed = 32'h00000017;
    err_count = 0;
    compares = 0;
    rst = 1'b1;
    {program_setup_mode, fault_ack, inactivity_enable, palm_station_en, pv, motion_cmd} = '0;
    {die_fault_evt, page_sel, clutch_pin, motor_on_pin, counter_reset_pin, lc_key_pin} = '0;
    {spm, stop_time, min_speed_set, motion_time_set, batch_size_set} = '0;
    {page_sum_calc, page_sum_stored} = '0;
    {lc_master_pin, lc_slave_pin} = 10'h3FF;
    {speed_threshold_a, brake_fail_set, brake_warn_set} = {16'hFFFF, 16'h0100, 16'h0080};
    lag = 8'h03;
    cyc(15);
    words("reset", nil, nil, nil);
    chk("counter_out", 16'h0001, {15'h0000, counter_out});
    @(posedge ref_clk);
    rst <= 1'b0;
    cyc(20);
    // Brake: equal to, just above and random stop times
    for (int k = 0; k < 8; k++) begin
      r = (k < 4) ? {16'h0000, (16'h0080 << (k / 2)) | 16'(k % 2)} : rnd();
      stop_time <= r[15:0];
      pulse(7'h20);
      words("brake", brk(r[15:0]), nil, nil);
      ackw(nil, nil, nil);
    end
    $display("test brake done");
    // Speed_threshold_a: clutch held, speed at threshold, speed above threshold
    speed_threshold_a <= 16'h0001;
    for (int k = 0; k < 3; k++) begin
      r = rnd() | 32'h00000002;
      clutch_pin <= (k == 0);
      cyc(12);
      spm <= (k == 1) ? 16'h0001 : r[15:0];
      pulse(7'h40);
      words("speed_threshold_a", (k == 2) ? oh(F1_SPEED_THRESHOLD_A) : nil, nil, nil);
      ackw(nil, nil, nil);
    end
    speed_threshold_a <= 16'hFFFF;
    $display("test speed_threshold_a done");
    // Two die sensor events back to back, then store and memory faults together
    r = rnd();
    @(posedge ref_clk);
    die_fault_evt <= r[7:0] | 8'h01;
    @(posedge ref_clk);
    die_fault_evt <= 8'h80;
    @(posedge ref_clk);
    die_fault_evt <= 8'h00;
    pulse(7'h0C);
    words("die store", oh(F1_DIE), oh(F2_RAM_BAD), oh(F3_NV_STORE));
    chk("die list", {8'h00, r[7:0] | 8'h81}, {8'h00, die_fault_list});
    ackw(nil, nil, nil);
    $display("test die and store done");
    // Pages: match, mismatch in setup, mismatch in run, for each page
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      program_setup_mode <= (k % 3 == 1);
      page_sel <= (k > 2);
      page_sum_calc <= r[15:0];
      page_sum_stored <= r[15:0] ^ ((k % 3 == 0) ? nil : 16'h0001);
      pulse(7'h10);
      words("page", nil, (k % 3 == 2) ? oh(F2_PAGE0 + (k > 2)) : nil, nil);
      ackw(nil, nil, nil);
    end
    $display("test page done");
    // Setup strokes: fourteen pass, fifteenth flags; ack only clears in setup
    program_setup_mode <= 1'b1;
    for (int k = 1; k <= 15; k++) begin
      pulse(7'h01);
      words("strokes", nil, nil, (k == 15) ? oh(F3_STROKE_LIM) : nil);
    end
    program_setup_mode <= 1'b0;
    ackw(nil, nil, oh(F3_STROKE_LIM));
    program_setup_mode <= 1'b1;
    ackw(nil, nil, nil);
    program_setup_mode <= 1'b0;
    $display("test stroke limit done");
    // Batch of three parts drops the counter output without a fault
    batch_size_set <= 16'h0003;
    for (int k = 1; k <= 3; k++) begin
      pulse(7'h02);
      cyc(1);
      words("batch", nil, nil, nil);
      chk("counter_out", {15'h0000, k < 3}, {15'h0000, counter_out});
    end
    counter_reset_pin <= 1'b1;
    waitv("counter restore", 51, 1'b1, 20);
    counter_reset_pin <= 1'b0;
    batch_size_set <= nil;
    $display("test batch done");
    // Motion: a prompt press passes, a stalled one is flagged after 2 ms
    motion_time_set <= 16'h0002;
    lag <= 8'h05;
    motion_cmd <= 1'b1;
    cyc(40);
    words("prompt motion", nil, nil, nil);
    motion_cmd <= 1'b0;
    lag <= 8'h00;
    cyc(2);
    motion_cmd <= 1'b1;
    cyc(8);
    words("stall early", nil, nil, nil);
    waitv("lack of motion", F1_NO_MOTION, 1'b1, 40);
    motion_cmd <= 1'b0;
    motion_time_set <= nil;
    ackw(nil, nil, nil);
    $display("test motion done");
    // Inactivity with motor on, then minimum speed counted from motor start
    inactivity_enable <= 1'b1;
    motor_on_pin <= 1'b1;
    cyc(150);
    words("inactive early", nil, nil, nil);
    waitv("inactive", 32 + F3_INACTIVE, 1'b1, 200);
    inactivity_enable <= 1'b0;
    motor_on_pin <= 1'b0;
    cyc(12);
    ackw(nil, nil, nil);
    motor_on_pin <= 1'b1;
    min_speed_set <= 16'h0064;
    cyc(12);
    for (int k = 0; k < 3; k++) begin
      r = rnd();
      spm <= {10'h000, r[5:0]};
      pulse(7'h01);
      pulse(7'h40);
      words("min speed", (k == 2) ? oh(F1_MIN_SPEED) : nil, nil, nil);
    end
    motor_on_pin <= 1'b0;
    min_speed_set <= nil;
    ackw(nil, nil, nil);
    $display("test speed and inactivity done");
    // Curtains: each channel trips alone, an unkeyed one is ignored
    lc_key_pin <= 5'h01;
    cyc(12);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) lc_master_pin <= 5'h1E;
      else lc_slave_pin <= 5'h1E;
      waitv("trip", 50, 1'b1, 20);
      {lc_master_pin, lc_slave_pin} <= 10'h3FF;
      waitv("trip clear", 50, 1'b0, 20);
    end
    lc_master_pin <= 5'h1D;
    cyc(15);
    waitv("unkeyed", 50, 1'b0, 1);
    lc_master_pin <= 5'h1F;
    lc_key_pin <= 5'h04;
    palm_station_en <= 2'b10;
    waitv("reject", 49, 1'b1, 20);
    waitv("reject flag", 32 + F3_LC_CONFIG, 1'b1, 3);
    {lc_key_pin, palm_station_en} <= 7'h00;
    waitv("reject off", 49, 1'b0, 20);
    ackw(nil, nil, nil);
    $display("test curtain done");
    // Noisy pins: the clutch contact chatters every cycle until flagged
    n = 0;
    while (fault_word_two[F2_NOISY] !== 1'b1 && n < 1400) begin
      @(posedge ref_clk);
      clutch_pin <= ~clutch_pin;
      n++;
    end
    chk("noisy delay", 16'h0001, {15'h0000, n >= NOISY_CYCLES});
    clutch_pin <= 1'b0;
    cyc(12);
    words("noisy", nil, oh(F2_NOISY), nil);
    ackw(nil, nil, nil);
    $display("test noisy done");
    close_out();
  end
endmodule
`default_nettype wire
